// *** drive_power_defines.svh ***
// Constants of the drive power state control and status block.
// Assumes the object dictionary access port addresses by index and subindex.
`ifndef DRIVE_POWER_DEFINES_SVH
`define DRIVE_POWER_DEFINES_SVH

// ----------------------------------------
// Object indices and subindices
// ----------------------------------------
`define IDX_BOOT_INFO 16'h4042
`define IDX_ERROR_CODE 16'h603F
`define IDX_CONTROL_WORD 16'h6040
`define IDX_STATUS_WORD 16'h6041
`define SUB_ENTRY_COUNT 8'h00
`define SUB_BOOT_VERSION 8'h01
`define SUB_BOOT_BUS 8'h02
`define SUB_BOOT_HW_GROUP 8'h03

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ENTRY_COUNT 8'h03
`define RST_ERROR_CODE 16'h0000
`define RST_CONTROL_WORD 16'h0000
`define RST_STATUS_WORD 16'h0000

// ----------------------------------------
// Control word bit positions
// ----------------------------------------
`define CW_SWITCH_ON 0
`define CW_ENABLE_VOLTAGE 1
`define CW_QUICK_STOP 2
`define CW_ENABLE_OPERATION 3
`define CW_MODE_LO 4
`define CW_MODE_HI 6
`define CW_FAULT_RESET 7
`define CW_HALT 8
`define CW_MODE_TOP 9

// ----------------------------------------
// Status word bit positions
// ----------------------------------------
`define SW_ALERT 7
`define SW_BUS_LOCK 8
`define SW_EXTERNAL 9
`define SW_GOAL 10
`define SW_LIMIT 11
`define SW_MODE_LO 12
`define SW_MODE_HI 13
`define SW_CLOSED_LOOP 15

`endif

// *** drive_power_pkg.sv ***
// Types of the drive power state control and status block.
// Assumes drive_power_defines.svh holds the numbers.
`default_nettype none
package drive_power_pkg;

    // ----------------------------------------
    // Power state machine, Gray along the usual path
    // ----------------------------------------
    typedef enum logic [2:0] {
        ST_NOT_READY = 3'h0,
        ST_SW_ON_DISABLED = 3'h1,
        ST_READY = 3'h3,
        ST_SWITCHED_ON = 3'h2,
        ST_OP_ENABLED = 3'h6,
        ST_QUICK_STOP = 3'h7,
        ST_FAULT_REACTION = 3'h5,
        ST_FAULT = 3'h4
    } power_state_type;

    // ----------------------------------------
    // Object dictionary access request
    // ----------------------------------------
    typedef struct packed {
        logic valid;
        logic write;
        logic [15:0] index;
        logic [7:0] subindex;
        logic [31:0] wdata;
    } od_req_type;

    // ----------------------------------------
    // Answer to an access
    // ----------------------------------------
    typedef struct packed {
        logic ack;
        logic error;
        logic [31:0] rdata;
    } od_rsp_type;

    // ----------------------------------------
    // Drive conditions reported into the status word
    // ----------------------------------------
    typedef struct packed {
        logic bus_synced;
        logic special_mode;
        logic target_reached;
        logic limit_active;
        logic closed_loop;
        logic voltage_present;
        logic [1:0] mode_status;
    } drive_cond_type;

endpackage

`default_nettype wire

// *** drive_power_ctrl.sv ***
// Power state machine with control word, status word, error code and
// bootloader information objects behind one object dictionary port.
// Assumes every input comes from logic on clk_in; the fieldbus stack
// issues single-cycle requests and the motor logic reports its events.
`include "drive_power_defines.svh"
`timescale 1ns/10ps
`default_nettype none

module drive_power_ctrl #(
    parameter logic [15:0] BOOT_MAJOR = 16'h0000,
    parameter logic [15:0] BOOT_MINOR = 16'h0000,
    parameter logic [31:0] BOOT_BUS_FLAGS = 32'h0000_0000,
    parameter logic [31:0] BOOT_HW_GROUP = 32'h0000_0000,
    parameter int ERR_ENTRY_W = 32
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Object dictionary port
    input wire drive_power_pkg::od_req_type od_req_in,
    output drive_power_pkg::od_rsp_type od_rsp_out,
    // Error and warning events
    input wire logic error_valid_in,
    input wire logic [ERR_ENTRY_W-1:0] error_entry_in,
    input wire logic warning_valid_in,
    input wire logic clear_permit_in,
    input wire logic reaction_done_in,
    input wire logic stop_done_in,
    // Drive conditions
    input wire drive_power_pkg::drive_cond_type cond_in,
    input wire logic halt_mode_in,
    // Drive commands
    output drive_power_pkg::power_state_type power_state_out,
    output logic power_stage_on_out,
    output logic operation_on_out,
    output logic halt_out,
    output logic [3:0] mode_specific_bits_out
);

    // ----------------------------------------
    // Parameter check
    // ----------------------------------------
    if (ERR_ENTRY_W < 16) begin : g_bad_width
        $error("error entry narrower than the error code");
    end

    // ----------------------------------------
    // State
    // ----------------------------------------
    drive_power_pkg::power_state_type state_ff;
    drive_power_pkg::power_state_type nxt_state;
    logic [15:0] control_ff;
    logic [15:0] error_code_ff;
    logic warn_ff;
    logic reset_bit_ff;
    drive_power_pkg::od_rsp_type rsp_ff;

    // ----------------------------------------
    // Control word decode
    // ----------------------------------------
    wire logic switch_on_cmd = control_ff[`CW_SWITCH_ON];
    wire logic enable_voltage_cmd = control_ff[`CW_ENABLE_VOLTAGE];
    // Active low: a zero asks for the stop
    wire logic quick_stop_cmd = ~control_ff[`CW_QUICK_STOP];
    wire logic enable_operation_cmd = control_ff[`CW_ENABLE_OPERATION];
    wire logic fault_reset_cmd = control_ff[`CW_FAULT_RESET];
    // Fault reset acts on the rising edge only, so a held bit clears once
    wire logic fault_reset_edge = fault_reset_cmd & ~reset_bit_ff;
    wire logic clear_ok = fault_reset_edge & clear_permit_in;
    wire logic shutdown_cmd = enable_voltage_cmd & ~quick_stop_cmd & ~switch_on_cmd;
    wire logic on_cmd = enable_voltage_cmd & ~quick_stop_cmd & switch_on_cmd;

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            drive_power_pkg::ST_NOT_READY: begin
                nxt_state = drive_power_pkg::ST_SW_ON_DISABLED;
            end
            drive_power_pkg::ST_SW_ON_DISABLED: begin
                if (shutdown_cmd) begin
                    nxt_state = drive_power_pkg::ST_READY;
                end
            end
            drive_power_pkg::ST_READY: begin
                if (!enable_voltage_cmd || quick_stop_cmd) begin
                    nxt_state = drive_power_pkg::ST_SW_ON_DISABLED;
                end else if (switch_on_cmd) begin
                    nxt_state = drive_power_pkg::ST_SWITCHED_ON;
                end
            end
            drive_power_pkg::ST_SWITCHED_ON: begin
                if (!enable_voltage_cmd || quick_stop_cmd) begin
                    nxt_state = drive_power_pkg::ST_SW_ON_DISABLED;
                end else if (!switch_on_cmd) begin
                    nxt_state = drive_power_pkg::ST_READY;
                end else if (enable_operation_cmd) begin
                    nxt_state = drive_power_pkg::ST_OP_ENABLED;
                end
            end
            drive_power_pkg::ST_OP_ENABLED: begin
                if (!enable_voltage_cmd) begin
                    nxt_state = drive_power_pkg::ST_SW_ON_DISABLED;
                end else if (quick_stop_cmd) begin
                    nxt_state = drive_power_pkg::ST_QUICK_STOP;
                end else if (!switch_on_cmd) begin
                    nxt_state = drive_power_pkg::ST_READY;
                end else if (!enable_operation_cmd) begin
                    nxt_state = drive_power_pkg::ST_SWITCHED_ON;
                end
            end
            drive_power_pkg::ST_QUICK_STOP: begin
                // Leaves once the stop ramp is done, voltage is removed or a new error arrives
                if (!enable_voltage_cmd || stop_done_in) begin
                    nxt_state = drive_power_pkg::ST_SW_ON_DISABLED;
                end
            end
            drive_power_pkg::ST_FAULT_REACTION: begin
                if (reaction_done_in) begin
                    nxt_state = drive_power_pkg::ST_FAULT;
                end
            end
            drive_power_pkg::ST_FAULT: begin
                if (clear_ok && !error_valid_in) begin
                    nxt_state = drive_power_pkg::ST_SW_ON_DISABLED;
                end
            end
            default: begin
                nxt_state = drive_power_pkg::ST_NOT_READY;
            end
        endcase
        // A new error outranks every command
        if (error_valid_in && state_ff != drive_power_pkg::ST_FAULT
                && state_ff != drive_power_pkg::ST_FAULT_REACTION) begin
            nxt_state = drive_power_pkg::ST_FAULT_REACTION;
        end
    end

    // ----------------------------------------
    // Object dictionary decode
    // ----------------------------------------
    function automatic logic hit(input logic [15:0] idx, input logic [7:0] sub,
                                 input logic [15:0] want_idx,
                                 input logic [7:0] want_sub);
        hit = (idx == want_idx) && (sub == want_sub);
    endfunction

    wire logic [15:0] rq_idx = od_req_in.index;
    wire logic [7:0] rq_sub = od_req_in.subindex;
    wire logic hit_count = hit(rq_idx, rq_sub, `IDX_BOOT_INFO, `SUB_ENTRY_COUNT);
    wire logic hit_version = hit(rq_idx, rq_sub, `IDX_BOOT_INFO, `SUB_BOOT_VERSION);
    wire logic hit_bus = hit(rq_idx, rq_sub, `IDX_BOOT_INFO, `SUB_BOOT_BUS);
    wire logic hit_group = hit(rq_idx, rq_sub, `IDX_BOOT_INFO, `SUB_BOOT_HW_GROUP);
    wire logic hit_error = hit(rq_idx, rq_sub, `IDX_ERROR_CODE, 8'h00);
    wire logic hit_control = hit(rq_idx, rq_sub, `IDX_CONTROL_WORD, 8'h00);
    wire logic hit_status = hit(rq_idx, rq_sub, `IDX_STATUS_WORD, 8'h00);
    wire logic hit_ro = hit_count | hit_version | hit_bus | hit_group | hit_error
        | hit_status;
    wire logic hit_any = hit_ro | hit_control;
    // Only the control word takes writes; the rest refuse them untouched
    wire logic write_control = od_req_in.valid & od_req_in.write & hit_control;
    wire logic bad_access = ~hit_any | (od_req_in.write & hit_ro);

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    wire logic in_ready_group = state_ff == drive_power_pkg::ST_READY
        || state_ff == drive_power_pkg::ST_SWITCHED_ON
        || state_ff == drive_power_pkg::ST_OP_ENABLED;
    wire logic in_fault_group = state_ff == drive_power_pkg::ST_FAULT
        || state_ff == drive_power_pkg::ST_FAULT_REACTION;
    wire logic in_op_like = state_ff == drive_power_pkg::ST_OP_ENABLED
        || state_ff == drive_power_pkg::ST_QUICK_STOP
        || state_ff == drive_power_pkg::ST_FAULT_REACTION;
    wire logic ready_to_switch_on_flag = in_ready_group | in_op_like;
    wire logic switched_on_flag = state_ff == drive_power_pkg::ST_SWITCHED_ON
        || in_op_like;
    wire logic operation_flag = in_op_like;
    wire logic fault_flag = in_fault_group;
    wire logic voltage_applied_flag = cond_in.voltage_present;
    // Zero during quick stop, one in the ready group
    wire logic quick_stop_flag = in_ready_group;
    wire logic switch_on_disabled_flag = state_ff == drive_power_pkg::ST_SW_ON_DISABLED;
    wire logic [15:0] status_word = {
        cond_in.closed_loop && state_ff == drive_power_pkg::ST_OP_ENABLED,
        1'b0,
        cond_in.mode_status,
        cond_in.limit_active,
        cond_in.target_reached,
        ~cond_in.special_mode,
        cond_in.bus_synced,
        warn_ff,
        switch_on_disabled_flag,
        quick_stop_flag,
        voltage_applied_flag,
        fault_flag,
        operation_flag,
        switched_on_flag,
        ready_to_switch_on_flag
    };

    // ----------------------------------------
    // Read data select
    // ----------------------------------------
    wire logic [31:0] boot_version = {BOOT_MAJOR, BOOT_MINOR};
    wire logic [31:0] read_data =
        hit_count ? {24'h00_0000, `RST_ENTRY_COUNT} :
        hit_version ? boot_version :
        hit_bus ? BOOT_BUS_FLAGS :
        hit_group ? BOOT_HW_GROUP :
        hit_error ? {16'h0000, error_code_ff} :
        hit_control ? {16'h0000, control_ff} :
        hit_status ? {16'h0000, status_word} : 32'h0000_0000;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            state_ff <= drive_power_pkg::ST_NOT_READY;
            reset_bit_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            reset_bit_ff <= fault_reset_cmd;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            control_ff <= `RST_CONTROL_WORD;
        end else if (write_control) begin
            control_ff <= od_req_in.wdata[15:0];
        end
    end

    // A new error in the clearing cycle wins over the clear
    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            error_code_ff <= `RST_ERROR_CODE;
        end else if (error_valid_in) begin
            error_code_ff <= error_entry_in[15:0];
        end else if (clear_ok) begin
            error_code_ff <= `RST_ERROR_CODE;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            warn_ff <= 1'b0;
        end else if (warning_valid_in) begin
            warn_ff <= 1'b1;
        end else if (clear_ok) begin
            warn_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rsp_ff <= '0;
        end else begin
            rsp_ff.ack <= od_req_in.valid;
            rsp_ff.error <= od_req_in.valid & bad_access;
            rsp_ff.rdata <= (od_req_in.valid && !od_req_in.write && !bad_access)
                ? read_data : 32'h0000_0000;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign od_rsp_out = rsp_ff;
    assign power_state_out = state_ff;
    assign power_stage_on_out = switched_on_flag;
    assign operation_on_out = state_ff == drive_power_pkg::ST_OP_ENABLED;
    // Halt is gated by the mode so other modes never see it
    assign halt_out = control_ff[`CW_HALT] & halt_mode_in;
    assign mode_specific_bits_out = {control_ff[`CW_MODE_TOP],
        control_ff[`CW_MODE_HI:`CW_MODE_LO]};

endmodule

`default_nettype wire

// *** drive_power_master.sv ***
// Fieldbus master model issuing object dictionary accesses.
// Assumes a one-cycle request strobe and an answer one edge later.
`timescale 1ns/10ps
`default_nettype none

module drive_power_master (
    // Clock
    input wire logic clk_in,
    // Object port
    output var drive_power_pkg::od_req_type od_req_out,
    input wire drive_power_pkg::od_rsp_type od_rsp_in
);
    initial od_req_out = '0;

    task automatic xfer(input logic wr, input logic [15:0] idx, input logic [7:0] sub,
                        input logic [31:0] wd, output logic [31:0] rdv, output logic err);
        @(posedge clk_in);
        #1 od_req_out = {1'b1, wr, idx, sub, wd};
        @(posedge clk_in);
        #1 od_req_out.valid = 1'b0;
        // Released index, subindex and wdata flip (write keeps its value) so a stale value never passes for a fresh one
        od_req_out.index = ~idx;
        od_req_out.subindex = ~sub;
        od_req_out.wdata = ~wd;
        rdv = od_rsp_in.rdata;
        err = od_rsp_in.error;
        if (od_rsp_in.ack !== 1'b1) begin
            rdv = 'x;
        end
    endtask
endmodule

`default_nettype wire

// *** drive_power_ctrl_monitor.sv ***
// Checker of the object port and the power state outputs.
// Assumes it is bound onto drive_power_ctrl and sees only its ports.
`timescale 1ns/10ps
`default_nettype none

module drive_power_ctrl_monitor (
    // Clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // Watched ports
    input wire drive_power_pkg::od_req_type od_req_in,
    input wire drive_power_pkg::od_rsp_type od_rsp_out,
    input wire logic error_valid_in,
    input wire logic reaction_done_in,
    input wire logic halt_mode_in,
    input wire drive_power_pkg::power_state_type power_state_out,
    input wire logic power_stage_on_out,
    input wire logic operation_on_out,
    input wire logic halt_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);

    wire ctrl_hit = od_req_in.index == 16'h6040 && od_req_in.subindex == 8'h00;
    wire in_fault = power_state_out inside {drive_power_pkg::ST_FAULT_REACTION,
                                            drive_power_pkg::ST_FAULT};

    sequence s_ro_write;
        od_req_in.valid && od_req_in.write && !ctrl_hit;
    endsequence
    sequence s_refusal;
        od_rsp_out.ack && od_rsp_out.error && od_rsp_out.rdata == 32'h0;
    endsequence
    sequence s_ctrl_write;
        od_req_in.valid && od_req_in.write && ctrl_hit;
    endsequence

    chk_ack_follows: assert property (od_req_in.valid |=> od_rsp_out.ack)
        else $error("request not answered on the next edge");
    chk_no_stray_ack: assert property (od_rsp_out.ack |-> $past(od_req_in.valid))
        else $error("answer without a request");
    chk_ro_write_refused: assert property (s_ro_write |=> s_refusal)
        else $error("write to read-only object not refused");
    chk_ctrl_write_ok: assert property (s_ctrl_write |=> !od_rsp_out.error)
        else $error("control word write refused");
    chk_fault_entry: assert property (error_valid_in && !in_fault &&
        power_state_out != drive_power_pkg::ST_NOT_READY
        |=> power_state_out == drive_power_pkg::ST_FAULT_REACTION)
        else $error("error did not start the fault reaction");
    chk_fault_settle: assert property (power_state_out == drive_power_pkg::ST_FAULT_REACTION
        && reaction_done_in |=> power_state_out == drive_power_pkg::ST_FAULT)
        else $error("fault reaction did not settle into fault");
    chk_halt_gate: assert property (halt_out |-> halt_mode_in)
        else $error("halt outside a halt mode");
    chk_oper_state: assert property (operation_on_out ==
        (power_state_out == drive_power_pkg::ST_OP_ENABLED))
        else $error("operation output disagrees with state");
    chk_stage_decode: assert property (power_stage_on_out ==
        (power_state_out inside {drive_power_pkg::ST_SWITCHED_ON, drive_power_pkg::ST_OP_ENABLED,
        drive_power_pkg::ST_QUICK_STOP, drive_power_pkg::ST_FAULT_REACTION}))
        else $error("power stage output disagrees with state");
endmodule

bind drive_power_ctrl drive_power_ctrl_monitor u_drive_power_ctrl_monitor (
    .clk_in(clk_in), .reset_in(reset_in), .od_req_in(od_req_in), .od_rsp_out(od_rsp_out),
    .error_valid_in(error_valid_in), .reaction_done_in(reaction_done_in),
    .halt_mode_in(halt_mode_in), .power_state_out(power_state_out),
    .power_stage_on_out(power_stage_on_out), .operation_on_out(operation_on_out),
    .halt_out(halt_out));

`default_nettype wire

// *** drive_power_ctrl_test.sv ***
// Self-checking bench of the drive power state control block.
// Assumes the master model in drive_power_master.sv and a 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, (a), (b)); end end

module drive_power_ctrl_test;
    logic clk_in, reset_in, error_valid_in, warning_valid_in, clear_permit_in;
    logic reaction_done_in, stop_done_in, halt_mode_in, warn_exp, er;
    logic power_stage_on_out, operation_on_out, halt_out;
    logic [31:0] error_entry_in, rd, w, r;
    logic [3:0] mode_specific_bits_out;
    drive_power_pkg::od_req_type od_req_in;
    drive_power_pkg::od_rsp_type od_rsp_out;
    drive_power_pkg::drive_cond_type cond_in;
    drive_power_pkg::power_state_type power_state_out;
    integer seed = 32'hC358, fails = 0, checked = 0, cycles = 0, i;

    drive_power_ctrl #(.BOOT_MAJOR(16'h0004), .BOOT_MINOR(16'h0002),
        .BOOT_BUS_FLAGS(32'h0000_0005), .BOOT_HW_GROUP(32'h0000_0011)) u_drive_power_ctrl (
        .clk_in(clk_in), .reset_in(reset_in), .od_req_in(od_req_in), .od_rsp_out(od_rsp_out),
        .error_valid_in(error_valid_in), .error_entry_in(error_entry_in),
        .warning_valid_in(warning_valid_in), .clear_permit_in(clear_permit_in),
        .reaction_done_in(reaction_done_in), .stop_done_in(stop_done_in), .cond_in(cond_in),
        .halt_mode_in(halt_mode_in), .power_state_out(power_state_out),
        .power_stage_on_out(power_stage_on_out), .operation_on_out(operation_on_out),
        .halt_out(halt_out), .mode_specific_bits_out(mode_specific_bits_out));
    drive_power_master u_drive_power_master (.clk_in(clk_in), .od_req_out(od_req_in),
        .od_rsp_in(od_rsp_out));

    initial begin
        clk_in = 1'b0;
        forever #2 clk_in = ~clk_in;
    end

    // Whole run needs well under a thousand cycles
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            fails++;
            tally_and_finish();
        end
    end

    task tally_and_finish;
        if (fails == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    function logic [15:0] exp_sw(input drive_power_pkg::power_state_type st);
        logic [6:0] lo;
        case (st)
            drive_power_pkg::ST_SW_ON_DISABLED: lo = 7'h40;
            drive_power_pkg::ST_READY: lo = 7'h21;
            drive_power_pkg::ST_SWITCHED_ON: lo = 7'h23;
            drive_power_pkg::ST_OP_ENABLED: lo = 7'h27;
            drive_power_pkg::ST_QUICK_STOP: lo = 7'h07;
            drive_power_pkg::ST_FAULT_REACTION: lo = 7'h0F;
            drive_power_pkg::ST_FAULT: lo = 7'h08;
            default: lo = 7'h00;
        endcase
        lo[4] = cond_in.voltage_present;
        return {cond_in.closed_loop & (st == drive_power_pkg::ST_OP_ENABLED), 1'b0,
            cond_in.mode_status, cond_in.limit_active, cond_in.target_reached,
            ~cond_in.special_mode, cond_in.bus_synced, warn_exp, lo};
    endfunction

    task rd_obj(input logic [15:0] idx, input logic [7:0] sub);
        u_drive_power_master.xfer(1'b0, idx, sub, 32'h0, rd, er);
    endtask

    task wr_ctl(input logic [15:0] v);
        u_drive_power_master.xfer(1'b1, 16'h6040, 8'h00, {16'h0, v}, rd, er);
    endtask

    task check_state(input drive_power_pkg::power_state_type st);
        r = $random(seed);
        cond_in = r[7:0];
        rd_obj(16'h6041, 8'h00);
        `CHK(rd, {16'h0, exp_sw(st)})
        `CHK(power_state_out, st)
        `CHK(operation_on_out, st == drive_power_pkg::ST_OP_ENABLED)
        `CHK(power_stage_on_out, |(exp_sw(st) & 16'h0002))
    endtask

    initial begin
        reset_in = 1'b1;
        {error_valid_in, warning_valid_in, clear_permit_in} = 3'h0;
        {reaction_done_in, stop_done_in, halt_mode_in, warn_exp} = 4'h0;
        error_entry_in = 32'h0;
        cond_in = '0;
        repeat (6) @(posedge clk_in);
        #1 reset_in = 1'b0;
        // ----------------------------------------
        // Reset values and read-only objects
        // ----------------------------------------
        check_state(drive_power_pkg::ST_SW_ON_DISABLED);
        rd_obj(16'h4042, 8'h00);
        `CHK(rd, 32'h0000_0003)
        rd_obj(16'h4042, 8'h01);
        `CHK(rd, 32'h0004_0002)
        rd_obj(16'h4042, 8'h02);
        `CHK(rd, 32'h0000_0005)
        rd_obj(16'h4042, 8'h03);
        `CHK(rd, 32'h0000_0011)
        rd_obj(16'h603F, 8'h00);
        `CHK(rd, 32'h0)
        rd_obj(16'h4042, 8'h04);
        `CHK({er, rd}, {1'b1, 32'h0})
        u_drive_power_master.xfer(1'b1, 16'h6041, 8'h00, 32'hFFFF, rd, er);
        `CHK(er, 1'b1)
        u_drive_power_master.xfer(1'b1, 16'h603F, 8'h00, 32'h1234, rd, er);
        `CHK(er, 1'b1)
        rd_obj(16'h603F, 8'h00);
        `CHK(rd, 32'h0)
        check_state(drive_power_pkg::ST_SW_ON_DISABLED);
        // ----------------------------------------
        // Power-up path and quick stop
        // ----------------------------------------
        wr_ctl(16'h0006);
        check_state(drive_power_pkg::ST_READY);
        wr_ctl(16'h0007);
        check_state(drive_power_pkg::ST_SWITCHED_ON);
        wr_ctl(16'h000F);
        for (i = 0; i < 4; i++) begin
            check_state(drive_power_pkg::ST_OP_ENABLED);
        end
        wr_ctl(16'h000B);
        check_state(drive_power_pkg::ST_QUICK_STOP);
        @(posedge clk_in);
        #1 stop_done_in = 1'b1;
        @(posedge clk_in);
        #1 stop_done_in = 1'b0;
        check_state(drive_power_pkg::ST_SW_ON_DISABLED);
        // ----------------------------------------
        // Random control words
        // ----------------------------------------
        for (i = 0; i < 12; i++) begin
            w = (i == 0) ? 32'hFFFF_FFFF : $random(seed);
            halt_mode_in = w[31];
            wr_ctl(w[15:0]);
            `CHK(halt_out, w[8] & w[31])
            `CHK(mode_specific_bits_out, {w[9], w[6:4]})
            rd_obj(16'h6040, 8'h00);
            `CHK(rd, {16'h0, w[15:0]})
        end
        wr_ctl(16'h0000);
        check_state(drive_power_pkg::ST_SW_ON_DISABLED);
        // ----------------------------------------
        // Fault, warning and fault reset
        // ----------------------------------------
        w = $random(seed);
        @(posedge clk_in);
        #1 {error_valid_in, warning_valid_in, warn_exp} = 3'h7;
        error_entry_in = w;
        @(posedge clk_in);
        #1 {error_valid_in, warning_valid_in} = 2'h0;
        check_state(drive_power_pkg::ST_FAULT_REACTION);
        rd_obj(16'h603F, 8'h00);
        `CHK(rd, {16'h0, w[15:0]})
        reaction_done_in = 1'b1;
        check_state(drive_power_pkg::ST_FAULT);
        wr_ctl(16'h0080);
        check_state(drive_power_pkg::ST_FAULT);
        rd_obj(16'h603F, 8'h00);
        `CHK(rd, {16'h0, w[15:0]})
        wr_ctl(16'h0000);
        clear_permit_in = 1'b1;
        wr_ctl(16'h0080);
        warn_exp = 1'b0;
        check_state(drive_power_pkg::ST_SW_ON_DISABLED);
        rd_obj(16'h603F, 8'h00);
        `CHK(rd, 32'h0)
        tally_and_finish();
    end
endmodule

`default_nettype wire
